// >>> pspr_pkg.sv
// constants, types and decode helpers of the potentiometer serial port
// assumes one 100 MHz clock; serial pins arrive unsynchronised
`default_nettype none

package pspr_pkg;

  // ==========================================================
  // widths and frame
  localparam int PSPR_DW         = 8;
  localparam int PSPR_AW         = 5;
  localparam int PSPR_MEM_AW     = 4;
  localparam int PSPR_MEM_DEPTH  = 16;
  localparam int PSPR_FRAME_BITS = 16;
  localparam logic [4:0] PSPR_FRAME_CNT = 5'h10;

  // ==========================================================
  // instruction byte layout
  localparam int PSPR_OPC_HI_POS   = 7;
  localparam int PSPR_OPC_LO_POS   = 6;
  localparam int PSPR_ADDRESSED_POS = 5;
  localparam int PSPR_ADDR_HI_POS  = 4;
  localparam int PSPR_ADDR_LO_POS  = 0;

  // opcodes, with the addressed flag clear
  localparam logic [1:0] PSPR_OPC_NO_OPERATION = 2'h0;
  localparam logic [1:0] PSPR_OPC_CTRL_READ    = 2'h1;
  localparam logic [1:0] PSPR_OPC_CTRL_WRITE   = 2'h3;
  // opcodes, with the addressed flag set
  localparam logic [1:0] PSPR_OPC_READ      = 2'h0;
  localparam logic [1:0] PSPR_OPC_WRITE     = 2'h2;

  // ==========================================================
  // register map
  localparam logic [4:0] PSPR_ADDR_WIPER    = 5'h00;
  localparam logic [4:0] PSPR_ADDR_STORE_FIRST = 5'h01;
  localparam logic [4:0] PSPR_ADDR_STORE_LAST  = 5'h0E;
  localparam logic [4:0] PSPR_ADDR_CTRL        = 5'h10;
  localparam logic [3:0] PSPR_MEM_PWRUP_IDX = 4'h0;
  localparam int PSPR_CTRL_VOL_POS = 7;
  localparam logic [7:0] PSPR_CTRL_RESET = 8'h00;
  localparam logic [7:0] PSPR_DATA_ZERO  = 8'h00;
  localparam logic [7:0] PSPR_MEM_RESET  = 8'h00;

  typedef enum logic [1:0] {
    PSPR_ST_RECALL,
    PSPR_ST_LOAD,
    PSPR_ST_RUN
  } pspr_state_t;

  // ==========================================================
  // decode helpers
  function automatic logic [4:0] pspr_addr(input logic [7:0] instr);
    pspr_addr = instr[PSPR_ADDR_HI_POS:PSPR_ADDR_LO_POS];
  endfunction

  function automatic logic [1:0] pspr_opc(input logic [7:0] instr);
    pspr_opc = {instr[PSPR_OPC_HI_POS], instr[PSPR_OPC_LO_POS]};
  endfunction

  function automatic logic pspr_is_store(input logic [4:0] addr);
    pspr_is_store = (addr >= PSPR_ADDR_STORE_FIRST)
                    && (addr <= PSPR_ADDR_STORE_LAST);
  endfunction

  function automatic logic pspr_is_write(input logic [7:0] instr);
    pspr_is_write = instr[PSPR_ADDRESSED_POS]
      ? (pspr_opc(instr) == PSPR_OPC_WRITE)
      : (pspr_opc(instr) == PSPR_OPC_CTRL_WRITE);
  endfunction

  function automatic logic pspr_is_read(input logic [7:0] instr);
    pspr_is_read = instr[PSPR_ADDRESSED_POS]
      ? (pspr_opc(instr) == PSPR_OPC_READ)
      : (pspr_opc(instr) == PSPR_OPC_CTRL_READ);
  endfunction

  // unaddressed control opcodes force the control address
  function automatic logic [4:0] pspr_target(input logic [7:0] instr);
    pspr_target = instr[PSPR_ADDRESSED_POS] ? pspr_addr(instr)
                                            : PSPR_ADDR_CTRL;
  endfunction

endpackage

`default_nettype wire

// >>> pspr_nv_store.sv
// storage of the power-up position and the fourteen general bytes
// assumes writes and reads come from the serial port on the same clock
`default_nettype none
`timescale 1ns/10ps

module pspr_nv_store
  import pspr_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   we_i,
  input  wire logic [PSPR_MEM_AW-1:0] waddr_i,
  input  wire logic [PSPR_DW-1:0]     wdata_i,
  input  wire logic [PSPR_MEM_AW-1:0] raddr_i,
  output logic      [PSPR_DW-1:0]     rdata_o
);

  // ==========================================================
  // array
  // reset clears it: stands in for a factory-blank store
  logic [PSPR_DW-1:0] mem_r [PSPR_MEM_DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < PSPR_MEM_DEPTH; i++)
      begin
        mem_r[i] <= PSPR_MEM_RESET;
      end
    end
    else if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // registered read, one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= PSPR_MEM_RESET;
    end
    else
    begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule // pspr_nv_store

`default_nettype wire

// >>> pspr_serial_port.sv
// serial slave port of a single digital potentiometer
// assumes serial pins from the host, mode 0, sampled on clk_i
`default_nettype none
`timescale 1ns/10ps

module pspr_serial_port
  import pspr_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cs_n_i,
  input  wire logic               sck_i,
  input  wire logic               sdi_i,
  output logic                    sdo_o,
  output logic                    sdo_oe_o,
  output logic      [PSPR_DW-1:0] wiper_o
);

  // ==========================================================
  // pin synchronisers
  // slot 0 feeds slot 1 only; edges compare slots 1 and 2
  logic [2:0] cs_sync_r;
  logic [2:0] sck_sync_r;
  logic [1:0] sdi_sync_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_sync_r  <= 3'h7;
      sck_sync_r <= 3'h0;
      sdi_sync_r <= 2'h0;
    end
    else
    begin
      cs_sync_r  <= {cs_sync_r[1:0], cs_n_i};
      sck_sync_r <= {sck_sync_r[1:0], sck_i};
      sdi_sync_r <= {sdi_sync_r[0], sdi_i};
    end
  end

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  assign cs_low   = ~cs_sync_r[1];
  assign cs_fall  = cs_sync_r[2] & ~cs_sync_r[1];
  assign cs_rise  = ~cs_sync_r[2] & cs_sync_r[1];
  assign sck_rise = cs_low & ~sck_sync_r[2] & sck_sync_r[1];
  assign sck_fall = cs_low & sck_sync_r[2] & ~sck_sync_r[1];

  // ==========================================================
  // state
  pspr_state_t        state_r;
  logic [15:0]        shift_r;
  logic [4:0]         bit_cnt_r;
  logic [PSPR_DW-1:0] wiper_r;
  logic [PSPR_DW-1:0] ctrl_r;
  logic [PSPR_DW-1:0] resp_instr_r;
  logic [PSPR_DW-1:0] resp_data_r;
  logic               mem_rd_pend_r;
  logic [PSPR_DW-1:0] mem_rdata;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= PSPR_ST_RECALL;
    end
    else
    begin
      case (state_r)
        PSPR_ST_RECALL: state_r <= PSPR_ST_LOAD;
        PSPR_ST_LOAD:   state_r <= PSPR_ST_RUN;
        PSPR_ST_RUN:    state_r <= PSPR_ST_RUN;
        default:        state_r <= PSPR_ST_RECALL;
      endcase
    end
  end

  // ==========================================================
  // command decode of the latched frame
  logic [7:0] cmd_instr;
  logic [7:0] cmd_data;
  logic [4:0] cmd_addr;
  logic       exec;
  logic       do_write;
  logic       do_read;
  logic       ctrl_vol;
  logic       mem_we;
  logic [3:0] mem_raddr;

  // whatever was shifted in last counts, so a chain keeps its own word
  assign cmd_instr = shift_r[15:8];
  assign cmd_data  = shift_r[7:0];
  assign cmd_addr  = pspr_target(cmd_instr);
  // only a whole frame is acted on, and only at select release
  assign exec      = (state_r == PSPR_ST_RUN) && cs_rise
                     && (bit_cnt_r == PSPR_FRAME_CNT);
  assign do_write  = exec && pspr_is_write(cmd_instr);
  assign do_read   = exec && pspr_is_read(cmd_instr);
  assign ctrl_vol  = ctrl_r[PSPR_CTRL_VOL_POS];
  assign mem_we    = do_write && (pspr_is_store(cmd_addr)
                     || ((cmd_addr == PSPR_ADDR_WIPER) && !ctrl_vol));
  assign mem_raddr = (state_r == PSPR_ST_RUN) ? cmd_addr[3:0]
                                              : PSPR_MEM_PWRUP_IDX;

  pspr_nv_store u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (mem_we),
    .waddr_i (cmd_addr[3:0]),
    .wdata_i (cmd_data),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // ==========================================================
  // serial shifter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_r   <= 16'h0000;
      bit_cnt_r <= 5'h00;
    end
    else if (cs_fall)
    begin
      // preload the answer so it leaves ahead of the passed data
      shift_r   <= {resp_instr_r, resp_data_r};
      bit_cnt_r <= 5'h00;
    end
    else if (sck_rise)
    begin
      shift_r <= {shift_r[14:0], sdi_sync_r[1]};
      if (bit_cnt_r != PSPR_FRAME_CNT)
      begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      sdo_oe_o <= cs_low;
      if (cs_fall)
      begin
        sdo_o <= resp_instr_r[7];
      end
      else if (sck_fall)
      begin
        sdo_o <= shift_r[15];
      end
    end
  end

  // ==========================================================
  // wiper and control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wiper_r <= PSPR_DATA_ZERO;
    end
    else if (state_r == PSPR_ST_LOAD)
    begin
      wiper_r <= mem_rdata;
    end
    else if (do_write && (cmd_addr == PSPR_ADDR_WIPER))
    begin
      // both settings of bit 7 move the wiper at once
      wiper_r <= cmd_data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= PSPR_CTRL_RESET;
    end
    else if (do_write && (cmd_addr == PSPR_ADDR_CTRL))
    begin
      ctrl_r <= cmd_data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wiper_o <= PSPR_DATA_ZERO;
    end
    else
    begin
      wiper_o <= wiper_r;
    end
  end

  // ==========================================================
  // read answer for the next frame
  // store reads take one extra cycle; host must idle two cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      resp_instr_r  <= PSPR_DATA_ZERO;
      resp_data_r   <= PSPR_DATA_ZERO;
      mem_rd_pend_r <= 1'b0;
    end
    else
    begin
      mem_rd_pend_r <= 1'b0;
      if (exec)
      begin
        resp_instr_r <= cmd_instr;
        resp_data_r  <= PSPR_DATA_ZERO;
        if (do_read)
        begin
          if (cmd_addr == PSPR_ADDR_CTRL)
          begin
            resp_data_r <= ctrl_r;
          end
          else if ((cmd_addr == PSPR_ADDR_WIPER) && ctrl_vol)
          begin
            resp_data_r <= wiper_r;
          end
          else if ((cmd_addr == PSPR_ADDR_WIPER) || pspr_is_store(cmd_addr))
          begin
            mem_rd_pend_r <= 1'b1;
          end
        end
      end
      else if (mem_rd_pend_r)
      begin
        resp_data_r <= mem_rdata;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_vol_write;
    do_write && (cmd_addr == PSPR_ADDR_WIPER) && ctrl_vol;
  endsequence

  sequence seq_nv_write;
    do_write && (cmd_addr == PSPR_ADDR_WIPER) && !ctrl_vol;
  endsequence

  sequence seq_nv_read;
    do_read && (cmd_addr == PSPR_ADDR_WIPER) && !ctrl_vol;
  endsequence

  chk_vol_write_only: assert property (
    seq_vol_write |-> !mem_we ##2 (wiper_o == $past(cmd_data, 2)))
    else $error("volatile write missed wiper or touched store");

  chk_nv_write_store: assert property (
    seq_nv_write |-> mem_we && (mem_raddr == PSPR_MEM_PWRUP_IDX))
    else $error("power-up write not sent to store");

  chk_nv_copy_wiper: assert property (
    seq_nv_write |-> ##2 (wiper_o == $past(cmd_data, 2)))
    else $error("power-up write not copied to wiper");

  chk_nv_read_keeps: assert property (
    seq_nv_read |=> $stable(wiper_r) [*2])
    else $error("power-up read changed wiper");

  chk_ctrl_write_addr: assert property (
    do_write && (cmd_addr == PSPR_ADDR_CTRL) |=> ctrl_r == $past(cmd_data))
    else $error("control register write lost");

  chk_store_roundtrip: assert property (
    do_read && pspr_is_store(cmd_addr)
      |-> ##2 resp_data_r == $past(mem_rdata))
    else $error("general byte read answer wrong");

  chk_wiper_only_exec: assert property (
    (state_r == PSPR_ST_RUN) && $changed(wiper_r)
      |-> $past(exec) || $past(state_r == PSPR_ST_LOAD))
    else $error("wiper changed outside select release");

  chk_pass_through: assert property (
    sck_rise ##1 1'b1 |-> shift_r[0] == $past(sdi_sync_r[1]))
    else $error("input bit not shifted in");

  chk_frame_preload: assert property (
    cs_fall |=> sdo_o == $past(resp_instr_r[7]) && shift_r[7:0] ==
      $past(resp_data_r))
    else $error("answer not preloaded at frame start");

  chk_wiper_tap: assert property (
    ##1 wiper_o == $past(wiper_r))
    else $error("tap does not follow wiper");

endmodule // pspr_serial_port

`default_nettype wire

// >>> pspr_tmp_unused_guard.sv
// holds no logic; only the implicit-net switch pair
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

// >>> pspr_host_model.sv
// host side model: serial bus master, mode 0, one frame per call
// assumes clk_i is the bench clock and the bench calls frame()
`timescale 1ns/10ps
`default_nettype none

module pspr_host_model
(
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      sdi_o
);
  // ==========================================================
  // idle: select high, clock parked low
  initial
  begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    sdi_o  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ==========================================================
  // n bits, msb first; answer sampled just before each rise
  task automatic frame(input int n, input logic [31:0] w,
                       output logic [31:0] r);
    r = '0;
    wait_clk(1);
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o = w[i];
      wait_clk(6);
      // undriven answer turns into x so a compare cannot pass
      r[i] = sdo_oe_i ? sdo_i : 1'bx;
      sck_o = 1'b1;
      wait_clk(6);
      sck_o = 1'b0;
    end
    wait_clk(6);
    cs_n_o = 1'b1;
    // released data line must not look like the last bit
    sdi_o = ~sdi_o;
    wait_clk(12);
  endtask
endmodule // pspr_host_model

`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the potentiometer serial port
// assumes the host model drives all serial pins
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import pspr_pkg::*;
;

  logic               clk_i;
  logic               rst_i;
  logic               cs_n;
  logic               sck;
  logic               sdi;
  logic               sdo_o;
  logic               sdo_oe_o;
  logic [PSPR_DW-1:0] wiper_o;
  logic [31:0]        resp;
  int                 err_count = 0;
  int                 samples_checked = 0;

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  pspr_serial_port u_pspr_serial_port (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cs_n_i   (cs_n),
    .sck_i    (sck),
    .sdi_i    (sdi),
    .sdo_o    (sdo_o),
    .sdo_oe_o (sdo_oe_o),
    .wiper_o  (wiper_o)
  );

  pspr_host_model u_pspr_host_model (
    .clk_i    (clk_i),
    .sdo_i    (sdo_o),
    .sdo_oe_i (sdo_oe_o),
    .cs_n_o   (cs_n),
    .sck_o    (sck),
    .sdi_o    (sdi)
  );

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic send(input logic [7:0] ins, input logic [7:0] dat);
    u_pspr_host_model.frame(16, {16'h0000, ins, dat}, resp);
  endtask

  // answer comes back in the following no-operation frame
  task automatic rd(input logic [7:0] ins, input logic [7:0] exp);
    send(ins, 8'h00);
    send(8'h00, 8'h00);
    check("read answer", resp, {16'h0000, ins, exp});
  endtask

  task automatic chk_wiper(input logic [7:0] exp);
    check("wiper", {24'h000000, wiper_o}, {24'h000000, exp});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_control;
    chk_wiper(8'h00);
    rd(8'h40, 8'h00);
    send(8'hC0, 8'h80);
    rd(8'h40, 8'h80);
    rd(8'h30, 8'h80);
    // addressed write to the control address
    send(8'hB0, 8'h00);
    rd(8'h40, 8'h00);
    send(8'hB0, 8'h80);
    rd(8'h30, 8'h80);
  endtask

  task automatic t_volatile;
    send(8'hA0, 8'h55);
    chk_wiper(8'h55);
    rd(8'h20, 8'h55);
    send(8'hC0, 8'h00);
    rd(8'h20, 8'h00);
    chk_wiper(8'h55);
  endtask

  task automatic t_power_up;
    send(8'hA0, 8'h3C);
    chk_wiper(8'h3C);
    send(8'hC0, 8'h80);
    send(8'hA0, 8'h11);
    send(8'hC0, 8'h00);
    rd(8'h20, 8'h3C);
    chk_wiper(8'h11);
  endtask

  task automatic t_general;
    for (int a = 1; a <= 14; a++)
      send(8'hA0 | a[7:0], a[7:0] ^ 8'hA5);
    send(8'hAF, 8'h77);
    for (int a = 1; a <= 14; a++)
      rd(8'h20 | a[7:0], a[7:0] ^ 8'hA5);
    rd(8'h2F, 8'h00);
  endtask

  // short frame and no-operation must leave the wiper alone
  task automatic t_ignored;
    u_pspr_host_model.frame(12, 32'h00000A07, resp);
    chk_wiper(8'h11);
    send(8'h00, 8'h99);
    // a cut frame must not replace the echoed instruction
    check("short frame echo", resp, 32'h00000000);
    chk_wiper(8'h11);
  endtask

  // far device's word first, ours last; first word passes through
  task automatic t_chain;
    u_pspr_host_model.frame(32, 32'hA022A066, resp);
    check("chain pass", resp, 32'h0000A022);
    chk_wiper(8'h66);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    t_control();
    t_volatile();
    t_power_up();
    t_general();
    t_ignored();
    t_chain();
    finish_test();
  end

  // about 70 frames of roughly 210 clocks each
  initial
  begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
